// File: logic/sfcfe_map.svh
// Constants for the serial flash command front end: opcodes, field positions, reset values.
`ifndef SFCFE_MAP_SVH
`define SFCFE_MAP_SVH
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST_READ 8'h0b
`define SFCFE_OP_SECTOR_ERASE 8'h20
`define SFCFE_OP_BLOCK32_ERASE 8'h52
`define SFCFE_OP_BLOCK64_ERASE 8'hd8
`define SFCFE_OP_CHIP_ERASE_A 8'h60
`define SFCFE_OP_CHIP_ERASE_B 8'hc7
`define SFCFE_OP_BYTE_PROG 8'h02
`define SFCFE_OP_WORD_PROG 8'had
`define SFCFE_OP_STATUS_READ 8'h05
`define SFCFE_OP_STATUS1_READ 8'h35
`define SFCFE_OP_STATUS_UNLOCK 8'h50
`define SFCFE_OP_STATUS_WRITE 8'h01
`define SFCFE_OP_WRITE_ENABLE 8'h06
`define SFCFE_OP_WRITE_DISABLE 8'h04
`define SFCFE_OP_IDENT_READ_A 8'h90
`define SFCFE_OP_IDENT_READ_B 8'hab
`define SFCFE_OP_BUSY_OUT_ON 8'h70
`define SFCFE_OP_BUSY_OUT_OFF 8'h80
`define SFCFE_ADDR_TOP 18'h3ffff
`define SFCFE_SECTOR_LSB 12
`define SFCFE_BLOCK32_LSB 15
`define SFCFE_BLOCK64_LSB 16
`define SFCFE_ST_BUSY 0
`define SFCFE_ST_WEL 1
`define SFCFE_ST_BP0 2
`define SFCFE_ST_BP1 3
`define SFCFE_ST_AAI 6
`define SFCFE_ST_BPL 7
`define SFCFE_ST1_TSP 2
`define SFCFE_ST1_BSP 3
`define SFCFE_BP_RESET 2'h3
`define SFCFE_SECTOR_LOCK_RESET 2'h0
`define SFCFE_BUS_CYCLE_BITS 3'h7
`endif

// File: logic/sfcfe_pkg.sv
// Types shared by the serial flash command front end.
package sfcfe_pkg;
	typedef enum logic [6:0] {
		SFCFE_OPCODE = 7'h01,
		SFCFE_ADDR = 7'h02,
		SFCFE_DUMMY = 7'h04,
		SFCFE_DATA_IN = 7'h08,
		SFCFE_DATA_OUT = 7'h10,
		SFCFE_WAIT_END = 7'h20,
		SFCFE_IGNORE = 7'h40
	} sfcfe_phase_type;

	typedef enum logic [3:0] {
		SFCFE_OP_NONE = 4'h0,
		SFCFE_OP_ERASE = 4'h1,
		SFCFE_OP_PROG = 4'h2,
		SFCFE_OP_WPROG = 4'h3,
		SFCFE_OP_STWR = 4'h4
	} sfcfe_op_type;

	typedef struct packed {
		sfcfe_op_type op;
		logic [17:0] addr;
		logic [17:0] last;
		logic [7:0] data0;
		logic [7:0] data1;
		logic [7:0] stat0;
		logic [7:0] stat1;
		logic two_status;
	} sfcfe_req_type;

	typedef struct packed {
		logic [17:0] addr;
		logic rd_req;
	} sfcfe_mem_rd_type;
endpackage

// File: logic/sfcfe_front_end.sv
// Serial flash command front end: SPI framing, decode, protection and status.
`timescale 1ns/1ps
`include "sfcfe_map.svh"
// Behaviour
// - Top and bottom sector lock bits each lock their sector when one.
// - Program or erase touching a locked sector is not executed.
// - Reset clears both sector lock bits.
// - Reset sets both block-protect level bits, protecting every block.
// - Opcode, address and data move in eight-bit bus cycles.
// - Chip select fall starts a command; bits sampled on rising clock, MSB first.
// - Chip select rising mid bus cycle abandons the command.
// - Read 03h, fast read 0Bh with a dummy byte, both unbounded.
// - Erases 20h, 52h, D8h take three address bytes.
// - Chip erase is 60h or C7h alone.
// - Byte program 02h, word program ADh with address and data.
// - Status reads 05h and 35h repeat status until chip select rises.
// - Unlock 50h, status write 01h with one or two bytes, disable 04h.
// - Ident read 90h or ABh returns maker or part code by address bit zero.
// - 70h enables busy on serial output during word programming, 80h disables.
// - Erase address decoded down to bit 12, 15 or 16.
// - Read address increments per byte and wraps from top to zero.
// - Program to a protected area is ignored; host programs erased bytes.
// - Word program bytes go to even then odd address.
// - Busy bit reads one while an internal operation runs.
// - Write enable latch clears at reset, after status write, erase and byte program complete, and on 04h.
module sfcfe_front_end #(
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [7:0] PART_CODE = 8'h3c
) (
	// Core clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic core_en,
	// Serial link.
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// Write protect level for the lock-down bit.
	input wire logic wp_n,
	// Array read port, answered in the core domain.
	output sfcfe_pkg::sfcfe_mem_rd_type mem_rd,
	input wire logic [7:0] mem_rd_data,
	// Array operation port.
	output sfcfe_pkg::sfcfe_req_type op_req,
	output logic op_req_valid,
	input wire logic op_done,
	// Status view.
	output logic [7:0] status0,
	output logic [7:0] status1
);
	// MAKER_CODE and PART_CODE defaults are arbitrary.
	// ***********************************************
	// Link domain: shifter and decode.
	// ***********************************************
	sfcfe_pkg::sfcfe_phase_type phase_ff;
	logic [7:0] shift_ff;
	logic [2:0] bit_ff;
	logic [1:0] cnt_ff;
	logic [7:0] opc_ff;
	logic [17:0] addr_ff;
	logic [7:0] d0_ff;
	logic [7:0] d1_ff;
	logic [1:0] nd_ff;
	logic [7:0] out_ff;
	logic [7:0] out_byte;
	logic so_oe_ff;
	logic busy_mode_ff;
	logic done_tgl_ff;
	logic [7:0] st0_l1_ff, st0_l2_ff, st1_l1_ff, st1_l2_ff;
	logic aai_l1_ff, aai_l2_ff, busy_l1_ff, busy_l2_ff;
	logic busy_ff, wel_ff, aai_ff, bpl_ff, unlock_ff;
	logic [7:0] rd_data_ff;
	logic rd_tgl_ff;
	logic [7:0] nxt_shift;
	logic byte_end;
	logic [7:0] in_byte;
	logic [7:0] rd_byte;

	assign nxt_shift = {shift_ff[6:0], spi_si};
	assign byte_end = (bit_ff == `SFCFE_BUS_CYCLE_BITS);
	assign in_byte = nxt_shift;

	// Status crosses into the link domain in two stages.
	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			st0_l1_ff <= 8'h00;
			st0_l2_ff <= 8'h00;
			st1_l1_ff <= 8'h00;
			st1_l2_ff <= 8'h00;
		end else begin
			st0_l1_ff <= status0;
			st0_l2_ff <= st0_l1_ff;
			st1_l1_ff <= status1;
			st1_l2_ff <= st1_l1_ff;
		end
	end

	// The core answers a read within a few core cycles, long before the falling link
	// edge that loads the byte, so the word is held stable when the link side takes it.
	assign rd_byte = rd_data_ff;

	// Command sequencing; chip select high holds the sequencer in reset.
	always_ff @(posedge spi_clk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			phase_ff <= sfcfe_pkg::SFCFE_OPCODE;
			shift_ff <= 8'h00;
			bit_ff <= 3'h0;
			cnt_ff <= 2'h0;
			opc_ff <= 8'h00;
			nd_ff <= 2'h0;
		end else begin
			shift_ff <= nxt_shift;
			bit_ff <= bit_ff + 3'h1;
			if (byte_end) begin
				case (phase_ff)
					sfcfe_pkg::SFCFE_OPCODE: begin
						opc_ff <= in_byte;
						cnt_ff <= 2'h0;
						case (in_byte)
							`SFCFE_OP_READ, `SFCFE_OP_FAST_READ, `SFCFE_OP_SECTOR_ERASE,
							`SFCFE_OP_BLOCK32_ERASE, `SFCFE_OP_BLOCK64_ERASE,
							`SFCFE_OP_BYTE_PROG, `SFCFE_OP_IDENT_READ_A,
							`SFCFE_OP_IDENT_READ_B: begin
								phase_ff <= sfcfe_pkg::SFCFE_ADDR;
							end
							`SFCFE_OP_WORD_PROG: begin
								phase_ff <= aai_l2_ff ? sfcfe_pkg::SFCFE_DATA_IN
									: sfcfe_pkg::SFCFE_ADDR;
							end
							`SFCFE_OP_STATUS_READ, `SFCFE_OP_STATUS1_READ: begin
								phase_ff <= sfcfe_pkg::SFCFE_DATA_OUT;
							end
							`SFCFE_OP_STATUS_WRITE: begin
								phase_ff <= sfcfe_pkg::SFCFE_DATA_IN;
							end
							`SFCFE_OP_CHIP_ERASE_A, `SFCFE_OP_CHIP_ERASE_B,
							`SFCFE_OP_WRITE_ENABLE, `SFCFE_OP_WRITE_DISABLE,
							`SFCFE_OP_STATUS_UNLOCK, `SFCFE_OP_BUSY_OUT_ON,
							`SFCFE_OP_BUSY_OUT_OFF: begin
								phase_ff <= sfcfe_pkg::SFCFE_WAIT_END;
							end
							default: begin
								phase_ff <= sfcfe_pkg::SFCFE_IGNORE;
							end
						endcase
					end
					sfcfe_pkg::SFCFE_ADDR: begin
						cnt_ff <= cnt_ff + 2'h1;
						if (cnt_ff == 2'h2) begin
							cnt_ff <= 2'h0;
							if (opc_ff == `SFCFE_OP_FAST_READ) begin
								phase_ff <= sfcfe_pkg::SFCFE_DUMMY;
							end else if (opc_ff == `SFCFE_OP_BYTE_PROG
								|| opc_ff == `SFCFE_OP_WORD_PROG) begin
								phase_ff <= sfcfe_pkg::SFCFE_DATA_IN;
							end else if (opc_ff == `SFCFE_OP_READ
								|| opc_ff == `SFCFE_OP_IDENT_READ_A
								|| opc_ff == `SFCFE_OP_IDENT_READ_B) begin
								phase_ff <= sfcfe_pkg::SFCFE_DATA_OUT;
							end else begin
								phase_ff <= sfcfe_pkg::SFCFE_WAIT_END;
							end
						end
					end
					sfcfe_pkg::SFCFE_DUMMY: begin
						phase_ff <= sfcfe_pkg::SFCFE_DATA_OUT;
					end
					sfcfe_pkg::SFCFE_DATA_IN: begin
						if (nd_ff != 2'h3) begin
							nd_ff <= nd_ff + 2'h1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Address and data capture, read address increment with wrap.
	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			addr_ff <= 18'h00000;
			d0_ff <= 8'h00;
			d1_ff <= 8'h00;
		end else if (!spi_cs_n && byte_end) begin
			if (phase_ff == sfcfe_pkg::SFCFE_ADDR) begin
				addr_ff <= {addr_ff[9:0], in_byte};
			end else if (phase_ff == sfcfe_pkg::SFCFE_DATA_IN) begin
				if (nd_ff == 2'h0) begin
					d0_ff <= in_byte;
				end else if (nd_ff == 2'h1) begin
					d1_ff <= in_byte;
				end
			end else if (phase_ff == sfcfe_pkg::SFCFE_DATA_OUT
				&& (opc_ff == `SFCFE_OP_READ || opc_ff == `SFCFE_OP_FAST_READ)) begin
				addr_ff <= (addr_ff == `SFCFE_ADDR_TOP) ? 18'h00000
					: addr_ff + 18'h00001;
			end
		end
	end

	// Read request toggle: raised at the byte boundary that sets the address of the next
	// output byte, so the core has half a link period to fetch it.
	logic rd_go;
	assign rd_go = !spi_cs_n && byte_end
		&& (phase_ff == sfcfe_pkg::SFCFE_DATA_OUT || phase_ff == sfcfe_pkg::SFCFE_DUMMY
		|| (phase_ff == sfcfe_pkg::SFCFE_ADDR && cnt_ff == 2'h2))
		&& (opc_ff == `SFCFE_OP_READ || opc_ff == `SFCFE_OP_FAST_READ);

	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			rd_tgl_ff <= 1'b0;
		end else if (rd_go) begin
			rd_tgl_ff <= ~rd_tgl_ff;
		end
	end

	// Output byte selection, loaded at each byte boundary.
	always_comb begin
		out_byte = 8'hff;
		case (opc_ff)
			`SFCFE_OP_STATUS_READ: out_byte = st0_l2_ff;
			`SFCFE_OP_STATUS1_READ: out_byte = st1_l2_ff;
			`SFCFE_OP_IDENT_READ_A, `SFCFE_OP_IDENT_READ_B: begin
				out_byte = addr_ff[0] ? PART_CODE : MAKER_CODE;
			end
			`SFCFE_OP_READ, `SFCFE_OP_FAST_READ: out_byte = rd_byte;
			default: out_byte = 8'hff;
		endcase
	end

	// Serial output changes on the falling clock edge.
	always_ff @(negedge spi_clk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			out_ff <= 8'h00;
			so_oe_ff <= 1'b0;
		end else if (phase_ff == sfcfe_pkg::SFCFE_DATA_OUT) begin
			so_oe_ff <= 1'b1;
			if (bit_ff == 3'h0) begin
				out_ff <= out_byte;
			end else begin
				out_ff <= {out_ff[6:0], 1'b0};
			end
		end else begin
			so_oe_ff <= busy_mode_ff && aai_l2_ff;
		end
	end

	assign spi_so = (phase_ff == sfcfe_pkg::SFCFE_DATA_OUT) ? out_ff[7]
		: ~busy_l2_ff;
	assign spi_so_oe = so_oe_ff;

	// ***********************************************
	// Frame end: capture the finished command.
	// ***********************************************
	logic [7:0] done_op_ff;
	logic [17:0] done_addr_ff;
	logic [7:0] done_d0_ff, done_d1_ff;
	logic [1:0] done_nd_ff;
	logic complete;

	// Abandoned mid-cycle commands never complete.
	assign complete = (bit_ff == 3'h0) && (phase_ff == sfcfe_pkg::SFCFE_WAIT_END
		|| phase_ff == sfcfe_pkg::SFCFE_DATA_IN);

	always_ff @(posedge spi_cs_n or posedge rst) begin
		if (rst) begin
			done_tgl_ff <= 1'b0;
			done_op_ff <= 8'h00;
			done_addr_ff <= 18'h00000;
			done_d0_ff <= 8'h00;
			done_d1_ff <= 8'h00;
			done_nd_ff <= 2'h0;
			busy_mode_ff <= 1'b0;
		end else if (complete) begin
			done_tgl_ff <= ~done_tgl_ff;
			done_op_ff <= opc_ff;
			done_addr_ff <= addr_ff;
			done_d0_ff <= d0_ff;
			done_d1_ff <= d1_ff;
			done_nd_ff <= nd_ff;
			if (opc_ff == `SFCFE_OP_BUSY_OUT_ON) begin
				busy_mode_ff <= 1'b1;
			end else if (opc_ff == `SFCFE_OP_BUSY_OUT_OFF) begin
				busy_mode_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			aai_l1_ff <= 1'b0;
			aai_l2_ff <= 1'b0;
			busy_l1_ff <= 1'b0;
			busy_l2_ff <= 1'b0;
		end else begin
			aai_l1_ff <= aai_ff;
			aai_l2_ff <= aai_l1_ff;
			busy_l1_ff <= busy_ff;
			busy_l2_ff <= busy_l1_ff;
		end
	end

	// ***********************************************
	// Core domain: status, protection and dispatch.
	// ***********************************************
	logic tg1_ff, tg2_ff, tg3_ff;
	logic rq1_ff, rq2_ff, rq3_ff;
	logic [1:0] bp_ff;
	logic tsp_ff, bsp_ff;
	logic [17:0] rd_addr_ff;
	logic wp1_ff, wp2_ff;
	logic [17:0] lo, hi, prot_lo;
	logic blocked, cmd_evt, st_locked;
	logic [17:0] wp_addr;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tg1_ff <= 1'b0;
			tg2_ff <= 1'b0;
			tg3_ff <= 1'b0;
			rq1_ff <= 1'b0;
			rq2_ff <= 1'b0;
			rq3_ff <= 1'b0;
			wp1_ff <= 1'b1;
			wp2_ff <= 1'b1;
		end else if (core_en) begin
			tg1_ff <= done_tgl_ff;
			tg2_ff <= tg1_ff;
			tg3_ff <= tg2_ff;
			rq1_ff <= rd_tgl_ff;
			rq2_ff <= rq1_ff;
			rq3_ff <= rq2_ff;
			wp1_ff <= wp_n;
			wp2_ff <= wp1_ff;
		end
	end

	assign cmd_evt = tg2_ff ^ tg3_ff;
	assign wp_addr = aai_ff ? rd_addr_ff : {done_addr_ff[17:1], 1'b0};

	// Target range of the finished command.
	always_comb begin
		lo = done_addr_ff;
		hi = done_addr_ff;
		case (done_op_ff)
			`SFCFE_OP_SECTOR_ERASE: begin
				lo = {done_addr_ff[17:`SFCFE_SECTOR_LSB], 12'h000};
				hi = {done_addr_ff[17:`SFCFE_SECTOR_LSB], 12'hfff};
			end
			`SFCFE_OP_BLOCK32_ERASE: begin
				lo = {done_addr_ff[17:`SFCFE_BLOCK32_LSB], 15'h0000};
				hi = {done_addr_ff[17:`SFCFE_BLOCK32_LSB], 15'h7fff};
			end
			`SFCFE_OP_BLOCK64_ERASE: begin
				lo = {done_addr_ff[17:`SFCFE_BLOCK64_LSB], 16'h0000};
				hi = {done_addr_ff[17:`SFCFE_BLOCK64_LSB], 16'hffff};
			end
			`SFCFE_OP_CHIP_ERASE_A, `SFCFE_OP_CHIP_ERASE_B: begin
				lo = 18'h00000;
				hi = `SFCFE_ADDR_TOP;
			end
			`SFCFE_OP_WORD_PROG: begin
				lo = wp_addr;
				hi = {wp_addr[17:1], 1'b1};
			end
			default: begin
			end
		endcase
		case (bp_ff)
			2'h1: prot_lo = 18'h30000;
			2'h2: prot_lo = 18'h20000;
			default: prot_lo = 18'h00000;
		endcase
	end

	// Lock check against block-protect level and both sector locks.
	assign blocked = (bp_ff != 2'h0 && hi >= prot_lo)
		|| (tsp_ff && hi[17:12] == 6'h3f)
		|| (bsp_ff && lo[17:12] == 6'h00)
		|| (done_op_ff == `SFCFE_OP_CHIP_ERASE_A && bp_ff != 2'h0)
		|| (done_op_ff == `SFCFE_OP_CHIP_ERASE_B && bp_ff != 2'h0);
	assign st_locked = !wp2_ff && bpl_ff;

	logic is_erase, is_prog;
	assign is_erase = done_op_ff == `SFCFE_OP_SECTOR_ERASE
		|| done_op_ff == `SFCFE_OP_BLOCK32_ERASE || done_op_ff == `SFCFE_OP_BLOCK64_ERASE
		|| done_op_ff == `SFCFE_OP_CHIP_ERASE_A || done_op_ff == `SFCFE_OP_CHIP_ERASE_B;
	assign is_prog = (done_op_ff == `SFCFE_OP_BYTE_PROG && done_nd_ff != 2'h0)
		|| (done_op_ff == `SFCFE_OP_WORD_PROG && done_nd_ff >= 2'h2);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
			wel_ff <= 1'b0;
			aai_ff <= 1'b0;
			bpl_ff <= 1'b0;
			unlock_ff <= 1'b0;
			bp_ff <= `SFCFE_BP_RESET;
			{tsp_ff, bsp_ff} <= `SFCFE_SECTOR_LOCK_RESET;
			op_req <= '0;
			op_req_valid <= 1'b0;
			rd_addr_ff <= 18'h00000;
		end else if (core_en) begin
			op_req_valid <= 1'b0;
			if (op_done) begin
				busy_ff <= 1'b0;
				if (!aai_ff) begin
					wel_ff <= 1'b0;
				end
			end
			if (cmd_evt && !busy_ff) begin
				case (done_op_ff)
					`SFCFE_OP_WRITE_ENABLE: wel_ff <= 1'b1;
					`SFCFE_OP_WRITE_DISABLE: begin
						wel_ff <= 1'b0;
						aai_ff <= 1'b0;
					end
					`SFCFE_OP_STATUS_UNLOCK: unlock_ff <= 1'b1;
					`SFCFE_OP_STATUS_WRITE: begin
						if ((wel_ff || unlock_ff) && !st_locked && done_nd_ff != 2'h0) begin
							bp_ff <= {done_d0_ff[`SFCFE_ST_BP1], done_d0_ff[`SFCFE_ST_BP0]};
							bpl_ff <= done_d0_ff[`SFCFE_ST_BPL];
							if (done_nd_ff >= 2'h2) begin
								tsp_ff <= done_d1_ff[`SFCFE_ST1_TSP];
								bsp_ff <= done_d1_ff[`SFCFE_ST1_BSP];
							end
						end
						wel_ff <= 1'b0;
						unlock_ff <= 1'b0;
					end
					default: begin
						if ((is_erase || is_prog) && wel_ff && !blocked) begin
							busy_ff <= 1'b1;
							op_req_valid <= 1'b1;
							op_req.op <= is_erase ? sfcfe_pkg::SFCFE_OP_ERASE
								: (done_op_ff == `SFCFE_OP_WORD_PROG ? sfcfe_pkg::SFCFE_OP_WPROG
								: sfcfe_pkg::SFCFE_OP_PROG);
							op_req.addr <= lo;
							op_req.last <= hi;
							op_req.data0 <= done_d0_ff;
							op_req.data1 <= done_d1_ff;
							if (done_op_ff == `SFCFE_OP_WORD_PROG) begin
								aai_ff <= 1'b1;
								rd_addr_ff <= hi + 18'h00001;
							end
						end else if (is_erase || is_prog) begin
							wel_ff <= wel_ff;
						end
					end
				endcase
			end
			if (rq2_ff ^ rq3_ff) begin
				rd_addr_ff <= addr_ff;
			end
		end
	end

	// Array read: fetch the byte at the current link address.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data_ff <= 8'h00;
		end else if (core_en && (rq2_ff ^ rq3_ff)) begin
			rd_data_ff <= mem_rd_data;
		end
	end

	assign mem_rd.addr = addr_ff;
	assign mem_rd.rd_req = rq2_ff ^ rq3_ff;
	assign status0 = {bpl_ff, aai_ff, 2'h0, bp_ff, wel_ff, busy_ff};
	assign status1 = {4'h0, bsp_ff, tsp_ff, 2'h0};
endmodule

// File: sim/sfcfe_chk_sva.sv
// Port assertions for the serial flash command front end.
`timescale 1ns/1ps
module sfcfe_chk (
	// Core clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Serial link.
	input wire logic spi_cs_n,
	input wire logic spi_so_oe,
	// Array operation port.
	input wire sfcfe_pkg::sfcfe_req_type op_req,
	input wire logic op_req_valid,
	input wire logic op_done,
	// Status view.
	input wire logic [7:0] status0,
	input wire logic [7:0] status1
);
	logic [18:0] bp_limit;
	logic mem_op;
	always_comb begin
		case (status0[3:2])
			2'h0: bp_limit = 19'h40000;
			2'h1: bp_limit = 19'h30000;
			2'h2: bp_limit = 19'h20000;
			default: bp_limit = 19'h00000;
		endcase
	end
	assign mem_op = op_req_valid && op_req.op != sfcfe_pkg::SFCFE_OP_STWR;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_busy_up;
		##[0:3] status0[0];
	endsequence
	sequence s_busy_down;
		##[1:4] !status0[0];
	endsequence
	a_reset_values: assert property ($fell(rst) |-> status0 == 8'h0c && status1 == 8'h00)
		else $error("status not at power-up values");
	a_busy_raise: assert property (op_req_valid |-> s_busy_up)
		else $error("busy not raised after request");
	a_busy_drop: assert property (op_done |-> s_busy_down)
		else $error("busy not dropped after done");
	a_busy_refuse: assert property ($past(status0[0]) && status0[0] |-> !op_req_valid)
		else $error("request issued while busy");
	a_req_single: assert property (op_req_valid |=> (!op_req_valid) [*8])
		else $error("requests closer than one command");
	a_wel_needed: assert property (mem_op |-> status0[1])
		else $error("memory request without write enable");
	a_block_range: assert property (mem_op |-> {1'b0, op_req.last} < bp_limit)
		else $error("request reaches a protected block");
	a_top_lock: assert property (mem_op && status1[2] |-> op_req.last < 18'h3f000)
		else $error("request reaches locked top sector");
	a_bottom_lock: assert property (mem_op && status1[3] |-> op_req.addr >= 18'h01000)
		else $error("request reaches locked bottom sector");
	a_erase_align: assert property (op_req_valid && op_req.op == sfcfe_pkg::SFCFE_OP_ERASE
		|-> op_req.addr[11:0] == 12'h000 && op_req.last[11:0] == 12'hfff)
		else $error("erase range not sector aligned");
	a_word_even: assert property (op_req_valid && op_req.op == sfcfe_pkg::SFCFE_OP_WPROG
		|-> !op_req.addr[0])
		else $error("word program starts at odd address");
	a_so_idle: assert property (spi_cs_n [*3] |-> !spi_so_oe)
		else $error("serial output driven while deselected");
endmodule
bind sfcfe_front_end sfcfe_chk u_chk (.core_clk(core_clk), .rst(rst), .spi_cs_n(spi_cs_n),
	.spi_so_oe(spi_so_oe), .op_req(op_req), .op_req_valid(op_req_valid), .op_done(op_done),
	.status0(status0), .status1(status1));

// File: sim/sfcfe_host.sv
// SPI host model that frames commands for the flash front end.
`timescale 1ns/1ps
module sfcfe_host (
	// Serial link.
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_si,
	input wire logic spi_so
);
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// Selects off the core clock grid; the clock idles low between frames.
	task automatic open_frame();
		#1.3;
		spi_cs_n = 1'b0;
		#80;
	endtask
	// Shifts n bits MSB first at 6.25 MHz, legal for both read kinds.
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			spi_si = tx[i];
			#80;
			spi_clk = 1'b1;
			rx[i] = spi_so;
			#80;
			spi_clk = 1'b0;
		end
	endtask
	// Deselects and leaves the data line at the inverse of its last bit.
	task automatic close_frame();
		spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		#160;
	endtask
endmodule

// File: sim/testbench.sv
// Self-checking testbench for the serial flash command front end.
`timescale 1ns/1ps
module testbench;
	// Arbitrary identification values.
	localparam logic [7:0] MAKER = 8'h5a;
	localparam logic [7:0] PART = 8'h3c;
	logic core_clk;
	logic rst;
	logic core_en;
	logic wp_n;
	logic op_done = 1'b0;
	logic spi_clk;
	logic spi_cs_n;
	logic spi_si;
	logic spi_so;
	logic spi_so_oe;
	logic [7:0] mem_rd_data;
	logic op_req_valid;
	logic [7:0] status0;
	logic [7:0] status1;
	sfcfe_pkg::sfcfe_mem_rd_type mem_rd;
	sfcfe_pkg::sfcfe_req_type op_req;
	sfcfe_pkg::sfcfe_req_type last_req;
	logic [7:0] rx;
	logic [7:0] eops [3] = '{8'h20, 8'h52, 8'hd8};
	logic [17:0] elo [3] = '{18'h12000, 18'h10000, 18'h10000};
	logic [17:0] ehi [3] = '{18'h12fff, 18'h17fff, 18'h1ffff};
	int mismatches = 0;
	int comparisons = 0;
	int req_count = 0;
	int n;
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	logic host_so;
	// A released output line shows the inverse, so a late enable reads as bad data.
	assign host_so = spi_so_oe ? spi_so : ~spi_so;
	sfcfe_host u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(host_so));
	sfcfe_front_end #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_dut (.core_clk(core_clk),
		.rst(rst), .core_en(core_en), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n), .mem_rd(mem_rd),
		.mem_rd_data(mem_rd_data), .op_req(op_req), .op_req_valid(op_req_valid),
		.op_done(op_done), .status0(status0), .status1(status1));
	// ****************************************
	// Array and operation responder
	// ****************************************
	function automatic logic [7:0] array_byte(input logic [17:0] a);
		return a[7:0] + a[17:10];
	endfunction
	assign mem_rd_data = array_byte(mem_rd.addr);
	always @(posedge core_clk) begin
		if (op_req_valid === 1'b1) begin
			last_req <= op_req;
			req_count <= req_count + 1;
			repeat (20) @(posedge core_clk);
			op_done <= 1'b1;
			@(posedge core_clk);
			op_done <= 1'b0;
		end
	end
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xb(input logic [7:0] b);
		u_host.shift(b, 8, rx);
	endtask
	task automatic settle();
		int k;
		u_host.close_frame();
		repeat (12) @(posedge core_clk);
		k = 0;
		while (status0[0] !== 1'b0 && k < 200) begin
			@(posedge core_clk);
			k++;
		end
		if (k == 200) chk("busy_wait", 0, 1);
	endtask
	task automatic hdr(input logic [7:0] op, input logic [23:0] a);
		u_host.open_frame();
		xb(op);
		for (int i = 2; i >= 0; i--) xb(a[i*8 +: 8]);
	endtask
	task automatic cmd1(input logic [7:0] op);
		u_host.open_frame();
		xb(op);
		settle();
	endtask
	task automatic prog(input logic [17:0] a, input logic [7:0] d);
		hdr(8'h02, {6'h00, a});
		xb(d);
		settle();
	endtask
	task automatic status_write_cmd(input logic [7:0] s0, input logic [7:0] s1);
		cmd1(8'h50);
		u_host.open_frame();
		xb(8'h01);
		xb(s0);
		xb(s1);
		settle();
	endtask
	task automatic rd_stat(input logic [7:0] op, input logic [7:0] exp);
		u_host.open_frame();
		xb(op);
		repeat (2) begin
			xb(8'h00);
			chk("status_stream", exp, rx);
		end
		settle();
	endtask
	task automatic want_req(input logic [3:0] op, input logic [17:0] a, input logic [17:0] l);
		chk("req_count", n + 1, req_count);
		chk("req_op", op, last_req.op);
		chk("req_addr", a, last_req.addr);
		chk("req_last", l, last_req.last);
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		mismatches++;
		give_verdict();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst = 1'b1;
		core_en = 1'b1;
		wp_n = 1'b1;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("status0", 8'h0c, status0);
		chk("status1", 8'h00, status1);
		rd_stat(8'h05, 8'h0c);
		rd_stat(8'h35, 8'h00);
		hdr(8'h90, 24'h000000);
		xb(8'h00);
		chk("maker", MAKER, rx);
		settle();
		hdr(8'hab, 24'h000001);
		xb(8'h00);
		chk("part", PART, rx);
		settle();
		done("reset_ident");
		n = req_count;
		cmd1(8'h06);
		chk("wel", 1, status0[1]);
		prog(18'h01234, 8'ha5);
		chk("bp_block", n, req_count);
		status_write_cmd(8'h00, 8'h0c);
		chk("status0", 8'h00, status0);
		chk("status1", 8'h0c, status1);
		n = req_count;
		cmd1(8'h06);
		prog(18'h3f800, 8'h00);
		cmd1(8'h06);
		hdr(8'h20, 24'h000100);
		settle();
		cmd1(8'h06);
		cmd1(8'hc7);
		cmd1(8'h04);
		prog(18'h01234, 8'ha5);
		chk("lock_block", n, req_count);
		cmd1(8'h06);
		prog(18'h01234, 8'ha5);
		want_req(sfcfe_pkg::SFCFE_OP_PROG, 18'h01234, 18'h01234);
		chk("data0", 8'ha5, last_req.data0);
		chk("status0", 8'h00, status0);
		done("protect_program");
		for (int i = 0; i < 3; i++) begin
			n = req_count;
			cmd1(8'h06);
			hdr(eops[i], 24'h012345);
			settle();
			want_req(sfcfe_pkg::SFCFE_OP_ERASE, elo[i], ehi[i]);
		end
		status_write_cmd(8'h00, 8'h00);
		for (int i = 0; i < 2; i++) begin
			n = req_count;
			cmd1(8'h06);
			cmd1(i == 0 ? 8'h60 : 8'hc7);
			want_req(sfcfe_pkg::SFCFE_OP_ERASE, 18'h00000, 18'h3ffff);
		end
		done("erase");
		cmd1(8'h70);
		n = req_count;
		cmd1(8'h06);
		hdr(8'had, 24'h000101);
		xb(8'h11);
		xb(8'h22);
		settle();
		want_req(sfcfe_pkg::SFCFE_OP_WPROG, 18'h00100, 18'h00101);
		chk("data0", 8'h11, last_req.data0);
		chk("data1", 8'h22, last_req.data1);
		cmd1(8'h04);
		cmd1(8'h80);
		chk("wel", 0, status0[1]);
		done("word_program");
		hdr(8'h03, 24'h03fffe);
		for (int i = 0; i < 3; i++) begin
			xb(8'h00);
			chk("read", array_byte(18'h3fffe + 18'(i)), rx);
		end
		settle();
		hdr(8'h0b, 24'h03ffff);
		xb(8'h00);
		for (int i = 0; i < 2; i++) begin
			xb(8'h00);
			chk("fast_read", array_byte(18'h3ffff + 18'(i)), rx);
		end
		settle();
		done("read");
		n = req_count;
		cmd1(8'h06);
		hdr(8'h02, 24'h001234);
		xb(8'ha5);
		u_host.shift(8'h5a, 3, rx);
		settle();
		chk("abort_req", n, req_count);
		cmd1(8'h04);
		u_host.open_frame();
		xb(8'h06);
		u_host.shift(8'h00, 1, rx);
		settle();
		chk("abort_wel", 0, status0[1]);
		done("abort");
		give_verdict();
	end
endmodule
